// >>> rtl/sps_buf_mem.sv
// Small buffer memory: one write port, one registered read port.
// Assumes the caller keeps the pointers; a same-cycle write to the read
// address is passed through so the read data never lags the pointer.
`timescale 1ns/100ps
`default_nettype none
module sps_buf_mem #(
  parameter int W = 32,
  parameter int AW = 6
) (
  input wire logic clk, // Peripheral clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [W-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address, next pointer value
  output logic [W-1:0] rdata // Registered read data
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // Array write, no reset needed on storage
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read register with write bypass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // sps_buf_mem
`default_nettype wire

// >>> rtl/sps_pkg.sv
// Constants shared by the serial port status block and its testbench.
// Assumes a 32-bit APB slave port with one register per aligned word.
package sps_pkg;
  localparam int SPS_DATA_W = 32;
  localparam int SPS_CNT_W = 6;
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_ISTAT = 8'h10;
  localparam logic [7:0] OFS_IMASK = 8'h14;
  // Control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_ENH = 1;
  localparam int CTL_IGN = 2;
  localparam int CTL_AUD = 3;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_WL_LO = 8;
  localparam logic [15:0] CTRL_MASK = 16'h1f3f;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // Status register fields
  localparam int ST_FRAME_ERROR_FLAG = 12;
  localparam int ST_BUSY = 11;
  localparam int ST_TUR = 8;
  localparam int ST_SHIFT_REGISTER_EMPTY_FLAG = 7;
  localparam int ST_ROV = 6;
  localparam int ST_RBE = 5;
  localparam int ST_TBE = 3;
  localparam int ST_TBF = 1;
  localparam int ST_RBF = 0;
  localparam logic [15:0] INT_MASK_BITS = 16'h1168;
  // Element count register fields
  localparam int CNT_RX_LO = 8;
  localparam int CNT_TX_LO = 0;
  // Word sizes in bits
  localparam logic [5:0] WB_8 = 6'h08;
  localparam logic [5:0] WB_16 = 6'h10;
  localparam logic [5:0] WB_32 = 6'h20;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [4:0] WL_DEFER = 5'h00;
  localparam logic [5:0] WL_PLUS = 6'h01;
  typedef enum logic [0:0] {LINK_IDLE, LINK_SHIFT} sps_link_t;
endpackage

// >>> rtl/sps_status_core.sv
// Serial port slave with variable word length, buffers and status flags.
// Assumes the link pins are asynchronous to pclk; sck is oversampled.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sps_status_core
  import sps_pkg::*;
#(
  parameter int CNT_W = SPS_CNT_W
) (
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic sck, // Link clock from master
  input wire logic ss_n, // Slave select, active low
  input wire logic mosi, // Serial data in
  output logic miso, // Serial data out
  output logic miso_oe, // Drive enable for miso
  output logic irq // Interrupt level
);
  localparam logic [CNT_W-1:0] C_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] C_FULL = {CNT_W{1'b1}};
  logic [2:0] pin_s1_reg, pin_s2_reg;
  logic sck_d_reg;
  sps_link_t link_reg, link_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] istat_reg, istat_next, imask_reg, imask_next;
  logic [31:0] prdata_reg, prdata_next, tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic miso_reg, miso_next, oe_reg, oe_next, irq_reg, irq_next;
  logic frm_reg, frm_next, tur_reg, tur_next, rov_reg, rov_next;
  logic [5:0] bit_reg, bit_next;
  logic [CNT_W-1:0] tx_wr_reg, tx_wr_next, tx_rd_reg, tx_rd_next, tx_cnt_reg, tx_cnt_next;
  logic [CNT_W-1:0] rx_wr_reg, rx_wr_next, rx_rd_reg, rx_rd_next, rx_cnt_reg, rx_cnt_next;
  logic [31:0] tx_rdata, rx_rdata, rx_word, wmask;
  logic [32:0] one_sh;
  logic [15:0] stat_word, ev;
  logic [5:0] wbits;
  logic en, enh, ign, halted, sck_rise, sck_fall, ss_act, mosi_s;
  logic apb_acc, apb_done, wr, rd, tx_push, tx_pop, rx_push, rx_pop, start_word, word_done;
  logic [CNT_W-1:0] cap;
  // Buffers hold full 32-bit words so depth is the same at any length
  sps_buf_mem #(.W(32), .AW(CNT_W)) u_tx_mem (
    .clk(pclk), .rst_n(presetn), .we(tx_push), .waddr(tx_wr_reg),
    .wdata(pwdata), .raddr(tx_rd_next), .rdata(tx_rdata)
  );
  sps_buf_mem #(.W(32), .AW(CNT_W)) u_rx_mem (
    .clk(pclk), .rst_n(presetn), .we(rx_push), .waddr(rx_wr_reg),
    .wdata(rx_word), .raddr(rx_rd_next), .rdata(rx_rdata)
  );
  // Decoded controls and synchronised pins
  assign en = ctrl_reg[CTL_EN];
  assign enh = ctrl_reg[CTL_ENH];
  assign ign = ctrl_reg[CTL_IGN];
  assign ss_act = !pin_s2_reg[1];
  assign mosi_s = pin_s2_reg[2];
  assign sck_rise = pin_s2_reg[0] && !sck_d_reg;
  assign sck_fall = !pin_s2_reg[0] && sck_d_reg;
  // A sticky underrun stops the link until software clears it, unless ign is set
  assign halted = tur_reg && !ign;
  // Standard mode behaves as a one-word holding buffer
  assign cap = enh ? C_FULL : C_ONE;
  // Serial word size from the length code or the size select
  always_comb begin
    if (!ctrl_reg[CTL_AUD] && (ctrl_reg[CTL_WL_LO +: 5] != WL_DEFER)) begin
      wbits = {1'b0, ctrl_reg[CTL_WL_LO +: 5]} + WL_PLUS;
    end else if (ctrl_reg[CTL_MODE_LO +: 2] == MODE_8) begin
      wbits = WB_8;
    end else if (ctrl_reg[CTL_MODE_LO +: 2] == MODE_16) begin
      wbits = WB_16;
    end else begin
      wbits = WB_32;
    end
    one_sh = 33'h000000001 << wbits;
    wmask = one_sh[31:0] - 32'h00000001;
    rx_word = {rx_sh_reg[30:0], mosi_s} & wmask;
  end
  // Status word from live state and sticky flags; shift-empty reads 0 while disabled
  always_comb begin
    stat_word = 16'h0000;
    stat_word[ST_FRAME_ERROR_FLAG] = frm_reg;
    stat_word[ST_BUSY] = (link_reg == LINK_SHIFT);
    stat_word[ST_TUR] = tur_reg;
    stat_word[ST_SHIFT_REGISTER_EMPTY_FLAG] = en && (tx_cnt_reg == '0) && !((link_reg == LINK_SHIFT) && (bit_reg != '0));
    stat_word[ST_ROV] = rov_reg;
    stat_word[ST_RBE] = (rx_cnt_reg == '0);
    stat_word[ST_TBE] = (tx_cnt_reg == '0);
    stat_word[ST_TBF] = (tx_cnt_reg == cap);
    stat_word[ST_RBF] = (rx_cnt_reg == cap);
  end
  // Next-state logic for bus, buffers, link and flags
  always_comb begin
    ctrl_next = ctrl_reg;
    istat_next = istat_reg;
    imask_next = imask_reg;
    link_next = link_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    bit_next = bit_reg;
    frm_next = frm_reg;
    tur_next = tur_reg;
    rov_next = rov_reg;
    ev = 16'h0000;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    start_word = 1'b0;
    word_done = 1'b0;
    // APB: one wait state, answer registered
    apb_acc = psel && penable;
    apb_done = apb_acc && pready_reg;
    wr = apb_done && pwrite;
    rd = apb_done && !pwrite;
    pready_next = apb_acc && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (apb_acc && !pready_reg) begin
      prdata_next = 32'h00000000;
      if (paddr == OFS_CTRL) begin
        prdata_next[15:0] = ctrl_reg;
      end else if (paddr == OFS_STAT) begin
        prdata_next[15:0] = stat_word;
      end else if (paddr == OFS_DATA) begin
        prdata_next = rx_rdata;
      end else if (paddr == OFS_CNT) begin
        prdata_next[CNT_RX_LO +: CNT_W] = rx_cnt_reg;
        prdata_next[CNT_TX_LO +: CNT_W] = tx_cnt_reg;
      end else if (paddr == OFS_ISTAT) begin
        prdata_next[15:0] = istat_reg;
      end else if (paddr == OFS_IMASK) begin
        prdata_next[15:0] = imask_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    // Register writes; protocol select is frozen while enabled
    if (wr && (paddr == OFS_CTRL)) begin
      ctrl_next = pwdata[15:0] & CTRL_MASK;
      ctrl_next[CTL_AUD] = en ? ctrl_reg[CTL_AUD] : pwdata[CTL_AUD];
    end
    if (wr && (paddr == OFS_STAT)) begin
      frm_next = frm_reg && pwdata[ST_FRAME_ERROR_FLAG];
      tur_next = tur_reg && pwdata[ST_TUR];
      rov_next = rov_reg && pwdata[ST_ROV];
    end
    if (wr && (paddr == OFS_ISTAT)) begin
      istat_next = istat_reg & ~pwdata[15:0];
    end
    if (wr && (paddr == OFS_IMASK)) begin
      imask_next = pwdata[15:0] & INT_MASK_BITS;
    end
    // Writes to a full buffer and reads of an empty one are dropped
    tx_push = wr && (paddr == OFS_DATA) && en && (tx_cnt_reg != cap);
    rx_pop = rd && (paddr == OFS_DATA) && (rx_cnt_reg != '0);
    // Link sequencing
    case (link_reg)
      LINK_IDLE: start_word = ss_act;
      LINK_SHIFT: begin
        if (!ss_act) begin
          link_next = LINK_IDLE;
          if (bit_reg != '0) begin
            frm_next = 1'b1;
            ev[ST_FRAME_ERROR_FLAG] = 1'b1;
          end
        end else if (sck_rise) begin
          rx_sh_next = {rx_sh_reg[30:0], mosi_s};
          bit_next = bit_reg + 6'h01;
          if ((bit_reg + 6'h01) == wbits) begin
            word_done = 1'b1;
            start_word = 1'b1;
          end
        end else if (sck_fall && (bit_reg != '0)) begin
          // No shift right after a load, the new MSB is already out
          tx_sh_next = {tx_sh_reg[30:0], 1'b0};
        end
      end
      default: link_next = LINK_IDLE;
    endcase
    // Finished word goes to the receive buffer unless it is full or the link is halted
    if (word_done && !halted) begin
      if (rx_cnt_reg == cap) begin
        rov_next = 1'b1;
        ev[ST_ROV] = 1'b1;
      end else begin
        rx_push = 1'b1;
        ev[ST_RBE] = 1'b1;
      end
    end
    // Start of a word: load the shifter or flag an underrun
    if (start_word) begin
      link_next = LINK_SHIFT;
      bit_next = 6'h00;
      tx_sh_next = 32'h00000000;
      if (!halted && (tx_cnt_reg != '0)) begin
        tx_sh_next = tx_rdata << (WB_32 - wbits);
        tx_pop = 1'b1;
        ev[ST_TBE] = 1'b1;
        tur_next = tur_next && !ign;
      end else if (!halted) begin
        tur_next = 1'b1;
        ev[ST_TUR] = 1'b1;
      end
    end
    // Buffer pointers
    tx_wr_next = tx_push ? tx_wr_reg + C_ONE : tx_wr_reg;
    tx_rd_next = tx_pop ? tx_rd_reg + C_ONE : tx_rd_reg;
    rx_wr_next = rx_push ? rx_wr_reg + C_ONE : rx_wr_reg;
    rx_rd_next = rx_pop ? rx_rd_reg + C_ONE : rx_rd_reg;
    tx_cnt_next = tx_cnt_reg + (tx_push ? C_ONE : '0) - (tx_pop ? C_ONE : '0);
    rx_cnt_next = rx_cnt_reg + (rx_push ? C_ONE : '0) - (rx_pop ? C_ONE : '0);
    // Disabled module holds the link idle and empties its buffers
    if (!en) begin
      link_next = LINK_IDLE;
      bit_next = 6'h00;
      tx_sh_next = 32'h00000000;
      tur_next = 1'b0;
      tx_wr_next = '0;
      tx_rd_next = '0;
      rx_wr_next = '0;
      rx_rd_next = '0;
      tx_cnt_next = '0;
      rx_cnt_next = '0;
      ev = 16'h0000;
    end
    tur_next = tur_next && ctrl_next[CTL_EN]; // Cleared in the very cycle the module is switched off
    // Events are applied after the clear so a same-cycle event wins
    istat_next = istat_next | ev;
    irq_next = |(istat_next & imask_next);
    miso_next = tx_sh_next[31];
    oe_next = en && ss_act;
  end
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 3'h2;
      pin_s2_reg <= 3'h2;
      sck_d_reg <= 1'b0;
      link_reg <= LINK_IDLE;
      ctrl_reg <= CTRL_RST;
      istat_reg <= 16'h0000;
      imask_reg <= 16'h0000;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      tx_sh_reg <= 32'h00000000;
      rx_sh_reg <= 32'h00000000;
      bit_reg <= 6'h00;
      frm_reg <= 1'b0;
      tur_reg <= 1'b0;
      rov_reg <= 1'b0;
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_cnt_reg <= '0;
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_cnt_reg <= '0;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {mosi, ss_n, sck};
      pin_s2_reg <= pin_s1_reg;
      sck_d_reg <= pin_s2_reg[0];
      link_reg <= link_next;
      ctrl_reg <= ctrl_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      bit_reg <= bit_next;
      frm_reg <= frm_next;
      tur_reg <= tur_next;
      rov_reg <= rov_next;
      tx_wr_reg <= tx_wr_next;
      tx_rd_reg <= tx_rd_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_wr_reg <= rx_wr_next;
      rx_rd_reg <= rx_rd_next;
      rx_cnt_reg <= rx_cnt_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      irq_reg <= irq_next;
    end
  end
  // Outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign miso = miso_reg;
  assign miso_oe = oe_reg;
  assign irq = irq_reg;
  // Checks on the flag behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_last_rx_read;
    rd && (paddr == OFS_DATA) && (rx_cnt_reg == C_ONE) && !rx_push;
  endsequence
  sequence s_part_word_drop;
    (link_reg == LINK_SHIFT) && en && !ss_act && (bit_reg != '0);
  endsequence
  AST_TUR_OFF: assert property (!ctrl_next[CTL_EN] |=> !tur_reg) else $error("underrun flag set while disabled");
  AST_FRAME_ERROR_FLAG: assert property (s_part_word_drop |=> frm_reg [*2]) else $error("frame error not flagged");
  AST_BUSY: assert property (en && ss_act |=> stat_word[ST_BUSY]) else $error("busy flag low");
  AST_SHIFT_REGISTER_EMPTY_FLAG: assert property ((tx_cnt_reg != '0) |-> !stat_word[ST_SHIFT_REGISTER_EMPTY_FLAG]) else $error("shift empty with data");
  AST_ROV: assert property (word_done && !halted && en && (rx_cnt_reg == cap) |=> rov_reg && $stable(rx_cnt_reg))
    else $error("overflow not flagged");
  AST_RBE_STD: assert property (s_last_rx_read |=> stat_word[ST_RBE]) else $error("rx empty not set on read");
  AST_RBE_ENH: assert property (enh |-> (stat_word[ST_RBE] == (rx_cnt_reg == '0))) else $error("rx empty mismatch");
  AST_TBF_ENH: assert property (enh && (tx_cnt_reg == C_FULL) |-> stat_word[ST_TBF]) else $error("tx full missing");
  AST_TUR_SET: assert property (start_word && en && ctrl_next[CTL_EN] && !halted && (tx_cnt_reg == '0) |=> tur_reg)
    else $error("underrun not flagged");
endmodule // sps_status_core
`default_nettype wire

// >>> tb/serial_port_status_and_word_length_test.sv
// Self-checking bench for the serial port status block.
// Assumes the APB slave in sps_status_core and the link master model beside it.
`timescale 1ns/100ps
`default_nettype none
module serial_port_status_and_word_length_test;
  import sps_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, got, m;
  logic pready, pslverr, sck, ss_n, mosi, miso, miso_oe, irq, err;
  logic [4:0] wlt [5] = '{5'h04, 5'h07, 5'h10, 5'h1f, 5'h00};
  int nbt [5] = '{5, 8, 17, 32, 16};
  int miscompares = 0;
  int checked = 0;
  // 20 MHz peripheral clock
  always #25 pclk = ~pclk;
  sps_status_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck),
    .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .irq(irq));
  sps_link_master PART (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  // Verdict and end of run
  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Word compare; case inequality so unknowns never match
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Read and compare the bits under a mask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd & mk);
  endtask
  // Control word: flags are audio, ignore, enhanced, enable from top down
  function automatic logic [31:0] ctl(input logic [3:0] f, input logic [1:0] md, input logic [4:0] wl);
    ctl = {19'h0, wl, 2'h0, md, f};
  endfunction
  task automatic irq_is(input logic e);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("reset status", OFS_STAT, 32'hffffffff, 32'h28);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // Ignored underrun stays live and does not stop reception
    wr(OFS_CTRL, ctl(4'h5, 2'h0, 5'h07));
    PART.frame(32'h96e11e69, 8, 8, got);
    rdc("live underrun", OFS_STAT, 32'h100, 32'h100);
    rdc("rx kept", OFS_DATA, 32'hffffffff, 32'h69);
    // Word lengths: code plus one, zero falls back to the size field
    for (int i = 0; i < 5; i++) begin
      m = 32'hffffffff >> (32 - nbt[i]);
      wr(OFS_CTRL, ctl(4'h5, 2'h1, wlt[i]));
      wr(OFS_DATA, 32'ha5c35a3c);
      rdc("pending", OFS_STAT, 32'h88, 32'h0);
      PART.frame(32'h96e11e69, nbt[i], nbt[i], got);
      chk("sent word", 32'ha5c35a3c & m, got);
      rdc("after word", OFS_STAT, 32'ha9, 32'h89);
      rdc("rx word", OFS_DATA, 32'hffffffff, 32'h96e11e69 & m);
      rdc("rx drained", OFS_STAT, 32'h21, 32'h20);
    end
    // Second word into a full standard buffer
    PART.frame(32'h1234, 16, 16, got);
    PART.frame(32'h4321, 16, 16, got);
    rdc("overflow", OFS_STAT, 32'h40, 32'h40);
    wr(OFS_STAT, 32'h1100);
    rdc("overflow cleared", OFS_STAT, 32'h40, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    // Partial word then a whole one: the error flag stays until cleared
    PART.frame(32'h0, 16, 5, got);
    rdc("frame error", OFS_STAT, 32'h1000, 32'h1000);
    PART.frame(32'h0, 16, 16, got);
    rdc("frame error held", OFS_STAT, 32'h1000, 32'h1000);
    apb(1'b0, OFS_DATA, 32'h0);
    wr(OFS_STAT, 32'h0140);
    rdc("frame error cleared", OFS_STAT, 32'h1000, 32'h0);
    // Interrupt raised, cleared, raised again and masked
    wr(OFS_IMASK, 32'h1000);
    irq_is(1'b1);
    wr(OFS_ISTAT, 32'h1000);
    irq_is(1'b0);
    PART.frame(32'h0, 16, 5, got);
    irq_is(1'b1);
    wr(OFS_IMASK, 32'h0);
    irq_is(1'b0);
    rdc("event kept", OFS_ISTAT, 32'h1000, 32'h1000);
    wr(OFS_STAT, 32'h0140);
    // Activity flag read in mid frame and after it
    fork
      PART.frame(32'h0, 16, 16, got);
      begin
        #3000;
        rdc("busy", OFS_STAT, 32'h800, 32'h800);
      end
    join
    rdc("idle", OFS_STAT, 32'h800, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    // Sticky underrun, cleared by disabling the module
    wr(OFS_CTRL, 32'h0);
    rdc("underrun off", OFS_STAT, 32'h100, 32'h0);
    wr(OFS_CTRL, ctl(4'h1, 2'h0, 5'h07));
    PART.frame(32'h5a, 8, 8, got);
    chk("zeros sent", 32'h0, got);
    rdc("underrun", OFS_STAT, 32'h100, 32'h100);
    wr(OFS_CTRL, 32'h0);
    rdc("underrun off", OFS_STAT, 32'h100, 32'h0);
    // Enhanced mode: fill until refused, then receive and drain
    wr(OFS_CTRL, ctl(4'h7, 2'h0, 5'h07));
    for (int i = 0; i < 63; i++) wr(OFS_DATA, i);
    rdc("tx count", OFS_CNT, 32'h3f3f, 32'h3f);
    rdc("tx full", OFS_STAT, 32'h0b, 32'h02);
    wr(OFS_CTRL, ctl(4'h7, 2'h0, 5'h1f));
    wr(OFS_DATA, 32'h99);
    rdc("depth kept", OFS_CNT, 32'h3f, 32'h3f);
    PART.frame(32'h80000001, 32, 32, got);
    chk("first out", 32'h0, got);
    PART.frame(32'h80000001, 32, 32, got);
    rdc("rx count", OFS_CNT, 32'h3f00, 32'h0200);
    rdc("rx filled", OFS_STAT, 32'h20, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    rdc("rx empty", OFS_STAT, 32'h20, 32'h20);
    // Reset in mid run restores the empties
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("reset again", OFS_STAT, 32'hffffffff, 32'h28);
    rdc("counts cleared", OFS_CNT, 32'hffffffff, 32'h0);
    tally_and_finish();
  end
endmodule // serial_port_status_and_word_length_test
`default_nettype wire

// >>> tb/sps_link_master.sv
// Behavioural serial link master facing the block's slave port.
// Assumes mode 0 timing and a 400 ns link clock; sck rests low between frames.
`timescale 1ns/100ps
`default_nettype none
module sps_link_master (
  output logic sck, // Link clock, low outside frames
  output logic ss_n, // Slave select, active low
  output logic mosi, // Serial data to the block
  input wire logic miso, // Serial data from the block
  input wire logic miso_oe // Block drives miso
);
  localparam time HALF = 200;
  // Idle levels before the first frame
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame of cut bits from an nb-bit word, MSB first; cut below nb leaves the word partial
  task automatic frame(input logic [31:0] tx, input int nb, input int cut, output logic [31:0] rx);
    rx = 32'h0;
    ss_n = 1'b0;
    #(2*HALF);
    for (int i = 0; i < cut; i++) begin
      mosi = tx[nb-1-i];
      #HALF;
      sck = 1'b1;
      // An undriven line must never pass for data
      rx = {rx[30:0], miso_oe ? miso : 1'bx};
      #HALF;
      sck = 1'b0;
    end
    #HALF;
    ss_n = 1'b1;
    // Released data line flips so a stale bit is never read as valid
    mosi = ~mosi;
    #(2*HALF);
  endtask
endmodule // sps_link_master
`default_nettype wire
